// file: design/msr_regs.svh
// Constants of the motion status readback block: codes, bit positions, resets.
`ifndef MSR_REGS_SVH
`define MSR_REGS_SVH

`define MSR_CMD_RD_DES_VEL   8'h07
`define MSR_CMD_RD_DES_POS   8'h08
`define MSR_CMD_RD_IDX_POS   8'h09
`define MSR_CMD_RD_ACT_POS   8'h0A
`define MSR_CMD_RD_ACT_VEL   8'h0B
`define MSR_CMD_RD_SIGNALS   8'h0C
`define MSR_CMD_RD_INT_SUM   8'h0D

`define MSR_LEN_FOUR         3'h4
`define MSR_LEN_TWO          3'h2
`define MSR_LEN_NONE         3'h0

`define MSR_SIG_HOST_IRQ     15
`define MSR_SIG_ACCEL        14
`define MSR_SIG_UDF          13
`define MSR_SIG_FWD          12
`define MSR_SIG_VEL_MODE     11
`define MSR_SIG_ON_TARGET    10
`define MSR_SIG_STOP_ON_ERR  9
`define MSR_SIG_NARROW_OUT   8
`define MSR_SIG_ARM_INDEX    0

`define MSR_SIG_RESET        16'h0100
`define MSR_STAT_BUSY        0
`define MSR_BYTE_MSB         31:24

`endif

// file: design/msr_pkg.sv
// Types shared by the motion status readback block.
package msr_pkg;

  typedef struct packed {
    logic       cs_n;
    logic       ps_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] data;
  } msr_host_t;

  typedef struct packed {
    logic filter_update;
    logic load_traj;
    logic traj_fwd;
    logic traj_vel;
    logic start_traj;
    logic traj_done;
    logic accel_loaded;
    logic err_stop;
    logic err_irq;
    logic narrow_out;
    logic wide_out;
    logic arm_index;
    logic index_pulse;
    logic sample_end;
  } msr_evt_t;

  typedef struct packed {
    logic [31:0] index_pos;
    logic [31:0] desired_pos;
    logic [31:0] actual_pos;
    logic [31:0] desired_vel;
    logic [15:0] actual_vel;
    logic [15:0] integ_sum;
  } msr_vals_t;

  typedef struct packed {
    logic wr_cmd;
    logic wr_data;
    logic rd_data;
    logic rd_stat;
  } msr_strb_t;

  typedef enum logic [1:0] {
    MSR_IDLE = 2'b00,
    MSR_LOAD = 2'b01,
    MSR_SEND = 2'b10
  } msr_state_t;

endpackage : msr_pkg

// file: design/msr_host_sync.sv
// Host strobe edge detector: turns the parallel port strobes into one-cycle pulses.
`timescale 1ns/1ns
module msr_host_sync (
  input  wire logic              clk_i,    // Device clock.
  input  wire logic              arst_n_i, // Asynchronous reset, active low.
  input  wire msr_pkg::msr_host_t host_i,  // Host port pins.
  output msr_pkg::msr_strb_t     strb_o,   // Registered strobe pulses.
  output logic [7:0]             cmd_o     // Byte taken at the last write strobe, on either port.
);

  logic wr_n_q;
  logic rd_n_q;
  logic ps_n_q;
  logic cs_n_q;

  // A write is taken where write falls; a read ends where read rises.
  wire wr_fall = wr_n_q & ~host_i.wr_n & ~host_i.cs_n;
  wire rd_rise = ~rd_n_q & host_i.rd_n & ~cs_n_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      ps_n_q <= 1'b1;
      cs_n_q <= 1'b1;
      strb_o <= '0;
      cmd_o  <= 8'h00;
    end
    else
    begin
      wr_n_q         <= host_i.wr_n;
      rd_n_q         <= host_i.rd_n;
      ps_n_q         <= host_i.ps_n;
      cs_n_q         <= host_i.cs_n;
      strb_o.wr_cmd  <= wr_fall & ~host_i.ps_n;
      strb_o.wr_data <= wr_fall & host_i.ps_n;
      strb_o.rd_data <= rd_rise & ps_n_q;
      strb_o.rd_stat <= rd_rise & ~ps_n_q;
      if (wr_fall)
      begin
        cmd_o <= host_i.data;
      end
    end
  end

endmodule : msr_host_sync

// file: design/msr_signals.sv
// Signals word flags kept from command and motion events.
`timescale 1ns/1ns
`include "msr_regs.svh"
module msr_signals (
  input  wire logic              clk_i,      // Device clock.
  input  wire logic              arst_n_i,   // Asynchronous reset, active low.
  input  wire msr_pkg::msr_evt_t evt_i,      // Command and motion events.
  input  wire logic              host_irq_i, // Host interrupt pin level.
  input  wire logic [7:0]        status_i,   // Status byte.
  output logic [15:0]            sig_o       // Signals word.
);

  logic fwd_pend_r;
  logic vel_pend_r;
  logic [15:0] sig_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fwd_pend_r <= 1'b0;
      vel_pend_r <= 1'b0;
      sig_r      <= `MSR_SIG_RESET;
    end
    else
    begin
      if (evt_i.load_traj)
      begin
        fwd_pend_r <= evt_i.traj_fwd;
        vel_pend_r <= evt_i.traj_vel;
      end
      if (evt_i.start_traj)
      begin
        sig_r[`MSR_SIG_FWD]      <= fwd_pend_r;
        sig_r[`MSR_SIG_VEL_MODE] <= vel_pend_r;
      end
      // Sets are written after clears so a coincident event is not lost.
      if (evt_i.sample_end)
        sig_r[`MSR_SIG_UDF] <= 1'b0;
      if (evt_i.filter_update)
        sig_r[`MSR_SIG_UDF] <= 1'b1;
      if (evt_i.start_traj)
        sig_r[`MSR_SIG_ON_TARGET] <= 1'b0;
      if (evt_i.traj_done)
        sig_r[`MSR_SIG_ON_TARGET] <= 1'b1;
      if (evt_i.start_traj)
        sig_r[`MSR_SIG_ACCEL] <= 1'b0;
      if (evt_i.accel_loaded)
        sig_r[`MSR_SIG_ACCEL] <= 1'b1;
      if (evt_i.err_irq)
        sig_r[`MSR_SIG_STOP_ON_ERR] <= 1'b0;
      if (evt_i.err_stop)
        sig_r[`MSR_SIG_STOP_ON_ERR] <= 1'b1;
      if (evt_i.wide_out)
        sig_r[`MSR_SIG_NARROW_OUT] <= 1'b0;
      if (evt_i.narrow_out)
        sig_r[`MSR_SIG_NARROW_OUT] <= 1'b1;
      if (evt_i.index_pulse)
        sig_r[`MSR_SIG_ARM_INDEX] <= 1'b0;
      if (evt_i.arm_index)
        sig_r[`MSR_SIG_ARM_INDEX] <= 1'b1;
    end
  end

  // Bit 15 and bits 7 to 1 are live copies, refreshed every cycle.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sig_o <= `MSR_SIG_RESET;
    else
      sig_o <= {host_irq_i, sig_r[14:8], status_i[7:1], sig_r[0]};
  end

endmodule : msr_signals

// file: design/msr_readback.sv
// Top of the motion status readback block: host port and reporting commands.
`timescale 1ns/1ns
`include "msr_regs.svh"
module msr_readback (
  input  wire logic               clk_i,       // Device clock, 50 MHz.
  input  wire logic               arst_n_i,    // Asynchronous reset, active low.
  input  wire logic               cs_n_i,      // Chip select, active low.
  input  wire logic               ps_n_i,      // Port select: low command, high data.
  input  wire logic               rd_n_i,      // Read strobe, active low.
  input  wire logic               wr_n_i,      // Write strobe, active low.
  input  wire logic [7:0]         data_i,      // Host data bus, in.
  output logic [7:0]              data_o,      // Host data bus, out.
  output logic                    data_oe_o,   // High while the device drives the bus.
  input  wire msr_pkg::msr_evt_t  evt_i,       // Command and motion events.
  input  wire msr_pkg::msr_vals_t vals_i,      // Live motion values.
  input  wire logic [7:0]         status_i,    // Status byte, bit 0 ignored.
  input  wire logic               core_busy_i, // Core is busy with a command.
  input  wire logic               host_irq_i,  // Host interrupt pin level.
  output logic                    cmd_err_o,   // Pulse: data read with nothing pending while the core is not busy.
  output logic                    busy_o,      // Busy as reported to the host.
  output logic [15:0]             signals_o    // Signals word.
);

  msr_pkg::msr_host_t host;
  msr_pkg::msr_strb_t strb;
  logic [7:0]         cmd_byte;

  msr_pkg::msr_state_t state_r;
  msr_pkg::msr_state_t state_nxt;
  logic [31:0]         shift_r;
  logic [31:0]         shift_nxt;
  logic [2:0]          left_r;
  logic [2:0]          left_nxt;
  logic                err_nxt;

  assign host.cs_n = cs_n_i;
  assign host.ps_n = ps_n_i;
  assign host.rd_n = rd_n_i;
  assign host.wr_n = wr_n_i;
  assign host.data = data_i;

  // Number of bytes a reporting command returns; zero for other codes.
  function automatic logic [2:0] msr_len(input logic [7:0] code);
    logic [2:0] len;
    len = `MSR_LEN_NONE;
    case (code)
      `MSR_CMD_RD_IDX_POS: len = `MSR_LEN_FOUR;
      `MSR_CMD_RD_DES_POS: len = `MSR_LEN_FOUR;
      `MSR_CMD_RD_ACT_POS: len = `MSR_LEN_FOUR;
      `MSR_CMD_RD_DES_VEL: len = `MSR_LEN_FOUR;
      `MSR_CMD_RD_ACT_VEL: len = `MSR_LEN_TWO;
      `MSR_CMD_RD_INT_SUM: len = `MSR_LEN_TWO;
      `MSR_CMD_RD_SIGNALS: len = `MSR_LEN_TWO;
      default:             len = `MSR_LEN_NONE;
    endcase
    return len;
  endfunction : msr_len

  // Value to send, aligned so its first byte sits in the top lane.
  function automatic logic [31:0] msr_snap(input logic [7:0]         code,
                                           input msr_pkg::msr_vals_t v,
                                           input logic [15:0]        sig);
    logic [31:0] val;
    val = 32'h0000_0000;
    case (code)
      `MSR_CMD_RD_IDX_POS: val = v.index_pos;
      `MSR_CMD_RD_DES_POS: val = v.desired_pos;
      `MSR_CMD_RD_ACT_POS: val = v.actual_pos;
      `MSR_CMD_RD_DES_VEL: val = v.desired_vel;
      `MSR_CMD_RD_ACT_VEL: val = {v.actual_vel, 16'h0000};
      `MSR_CMD_RD_INT_SUM: val = {v.integ_sum, 16'h0000};
      `MSR_CMD_RD_SIGNALS: val = {sig, 16'h0000};
      default:             val = 32'h0000_0000;
    endcase
    return val;
  endfunction : msr_snap

  msr_host_sync u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .host_i   (host),
    .strb_o   (strb),
    .cmd_o    (cmd_byte)
  );

  msr_signals u_sig (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .evt_i      (evt_i),
    .host_irq_i (host_irq_i),
    .status_i   (status_i),
    .sig_o      (signals_o)
  );

  // The one-cycle load state counts as busy so the first byte is ready.
  wire busy_now  = core_busy_i | (state_r == msr_pkg::MSR_LOAD);
  wire cmd_take  = strb.wr_cmd & ~busy_now;
  wire data_take = strb.rd_data & ~busy_now;
  wire [2:0] cmd_len = msr_len(cmd_byte);
  wire reading   = ~cs_n_i & ~rd_n_i;
  wire [7:0] stat_byte = {status_i[7:1], busy_now};

  always_comb
  begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    left_nxt  = left_r;
    err_nxt   = 1'b0;
    if (cmd_take)
    begin
      // Any new command aborts a transfer still in progress.
      if (cmd_len != `MSR_LEN_NONE)
      begin
        state_nxt = msr_pkg::MSR_LOAD;
        shift_nxt = msr_snap(cmd_byte, vals_i, signals_o);
        left_nxt  = cmd_len;
      end
      else
      begin
        state_nxt = msr_pkg::MSR_IDLE;
        left_nxt  = `MSR_LEN_NONE;
      end
    end
    else
    begin
      unique case (state_r)
        msr_pkg::MSR_IDLE:
        begin
          if (data_take)
            err_nxt = 1'b1;
        end
        msr_pkg::MSR_LOAD:
        begin
          state_nxt = msr_pkg::MSR_SEND;
        end
        msr_pkg::MSR_SEND:
        begin
          if (data_take)
          begin
            shift_nxt = {shift_r[23:0], 8'h00};
            left_nxt  = left_r - 3'h1;
            if (left_r == 3'h1)
              state_nxt = msr_pkg::MSR_IDLE;
          end
        end
        default:
        begin
          state_nxt = msr_pkg::MSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r   <= msr_pkg::MSR_IDLE;
      shift_r   <= 32'h0000_0000;
      left_r    <= `MSR_LEN_NONE;
      cmd_err_o <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      shift_r   <= shift_nxt;
      left_r    <= left_nxt;
      cmd_err_o <= err_nxt;
    end
  end

  // Bus output: status on the command port, port buffer on the data port.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
      busy_o    <= 1'b0;
    end
    else
    begin
      data_oe_o <= reading;
      busy_o    <= busy_now;
      if (reading)
        data_o <= ps_n_i ? shift_r[`MSR_BYTE_MSB] : stat_byte;
    end
  end

endmodule : msr_readback

// file: dv/msr_host_model.sv
// Host processor model for the parallel command, status and data ports.
`timescale 1ns/1ns
module msr_host_model (
  input  wire logic       clk_i,  // Device clock.
  input  wire logic [7:0] data_i, // Byte driven by the device.
  output logic            cs_n_o, // Chip select, active low.
  output logic            ps_n_o, // Port select.
  output logic            rd_n_o, // Read strobe, active low.
  output logic            wr_n_o, // Write strobe, active low.
  output logic [7:0]      data_o  // Byte driven by the host.
);
  initial
  begin
    {cs_n_o, ps_n_o, rd_n_o, wr_n_o} = 4'hF;
    data_o = 8'h00;
  end

  // Once released, the bus shows the inverse of the last byte, not a held copy.
  task automatic write_cmd(input logic [7:0] code);
    @(negedge clk_i);
    {cs_n_o, ps_n_o, wr_n_o} = 3'b000;
    data_o = code;
    repeat (2) @(negedge clk_i);
    {cs_n_o, ps_n_o, wr_n_o} = 3'b101;
    data_o = ~code;
    repeat (4) @(negedge clk_i);
  endtask : write_cmd

  task automatic read_byte(input logic port, output logic [7:0] b);
    @(negedge clk_i);
    {cs_n_o, ps_n_o, rd_n_o} = {1'b0, port, 1'b0};
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    b = data_i;
    {cs_n_o, rd_n_o} = 2'b11;
    repeat (3) @(negedge clk_i);
  endtask : read_byte

  task automatic wait_ready();
    logic [7:0] s;
    do
      read_byte(1'b0, s);
    while (s[0] !== 1'b0);
  endtask : wait_ready
endmodule : msr_host_model

// file: dv/msr_readback_chk.sv
// Assertion checker for the motion status readback top.
`timescale 1ns/1ns
module msr_readback_chk (
  input wire logic               clk_i,       // Device clock.
  input wire logic               arst_n_i,    // Reset, active low.
  input wire logic               cs_n_i,      // Chip select.
  input wire logic               ps_n_i,      // Port select.
  input wire logic               rd_n_i,      // Read strobe.
  input wire logic               wr_n_i,      // Write strobe.
  input wire logic [7:0]         data_i,      // Host data in.
  input wire logic [7:0]         data_o,      // Host data out.
  input wire logic               data_oe_o,   // Bus drive enable.
  input wire msr_pkg::msr_evt_t  evt_i,       // Events.
  input wire msr_pkg::msr_vals_t vals_i,      // Live values.
  input wire logic [7:0]         status_i,    // Status byte.
  input wire logic               core_busy_i, // Core busy.
  input wire logic               host_irq_i,  // Host interrupt level.
  input wire logic               cmd_err_o,   // Command error pulse.
  input wire logic               busy_o,      // Busy to host.
  input wire logic [15:0]        signals_o    // Signals word.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_cmd_take;
    $fell(wr_n_i) && !cs_n_i && !ps_n_i && !busy_o && !core_busy_i
      && data_i inside {[8'h07:8'h0D]};
  endsequence
  sequence s_load_cycle;
    ##3 busy_o ##1 !busy_o;
  endsequence

  a_cmd_load: assert property (s_cmd_take |-> s_load_cycle)
    else $error("reporting command gave no single load cycle");
  a_live_bits: assert property ($past(arst_n_i) |->
    {signals_o[15], signals_o[7:1]} == $past({host_irq_i, status_i[7:1]}))
    else $error("live signals bits do not follow inputs");
  a_oe_follows: assert property ($past(arst_n_i) |->
    data_oe_o == $past(!cs_n_i && !rd_n_i)) else $error("bus enable wrong");
  a_status_read: assert property ($past(!cs_n_i && !rd_n_i && !ps_n_i)
    && $past(arst_n_i) |-> data_o[7:1] == $past(status_i[7:1]))
    else $error("status byte read wrong");
  a_narrow_sets: assert property (evt_i.narrow_out |-> ##2 signals_o[8])
    else $error("narrow output flag not set");
  a_wide_clears: assert property (evt_i.wide_out && !evt_i.narrow_out
    |-> ##2 !signals_o[8]) else $error("narrow output flag not cleared");
  a_stop_sets: assert property (evt_i.err_stop |-> ##2 signals_o[9])
    else $error("stop on error flag not set");
  a_irq_clears: assert property (evt_i.err_irq && !evt_i.err_stop
    |-> ##2 !signals_o[9]) else $error("stop on error flag not cleared");
  a_udf_sets: assert property (evt_i.filter_update |-> ##2 signals_o[13])
    else $error("filter update flag not set");
  a_udf_clears: assert property (evt_i.sample_end && !evt_i.filter_update
    |-> ##2 !signals_o[13]) else $error("filter update flag not cleared");
  a_start_clears: assert property (evt_i.start_traj && !evt_i.traj_done
    && !evt_i.accel_loaded |-> ##2 !signals_o[10] && !signals_o[14])
    else $error("start did not clear target or accel flag");
  a_arm_sets: assert property (evt_i.arm_index |-> ##2 signals_o[0])
    else $error("index arm flag not set");
  a_err_pulse: assert property (cmd_err_o |=> !cmd_err_o)
    else $error("command error longer than one cycle");
endmodule : msr_readback_chk

bind msr_readback msr_readback_chk msr_readback_chk_i (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i), .ps_n_i(ps_n_i),
  .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .data_i(data_i), .data_o(data_o),
  .data_oe_o(data_oe_o), .evt_i(evt_i), .vals_i(vals_i), .status_i(status_i),
  .core_busy_i(core_busy_i), .host_irq_i(host_irq_i), .cmd_err_o(cmd_err_o),
  .busy_o(busy_o), .signals_o(signals_o));

// file: dv/msr_readback_tb.sv
// Self-checking testbench of the motion status readback block.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module msr_readback_tb;
  typedef struct { logic [7:0] cmd; int len; logic [31:0] val; } msr_row_t;
  localparam msr_pkg::msr_vals_t VALS = {32'hC0000000, 32'h12345678,
    32'h3FFFFFFF, 32'hFFFE8000, 16'hFFFE, 16'h0123};
  logic               clk_i, arst_n_i, core_busy_i, host_irq_i;
  logic               cs_n, ps_n, rd_n, wr_n, data_oe_o, cmd_err_o, busy_o;
  logic [7:0]         hdata, data_o, status_i, b;
  logic [15:0]        signals_o;
  msr_pkg::msr_evt_t  evt_i;
  msr_pkg::msr_vals_t vals_i;
  int                 num_errors = 0, checked = 0, errs = 0;
  msr_row_t           rows[6] = '{'{8'h09, 4, 32'hC0000000}, '{8'h08, 4, 32'h12345678},
    '{8'h0A, 4, 32'h3FFFFFFF}, '{8'h07, 4, 32'hFFFE8000},
    '{8'h0B, 2, 32'hFFFE0000}, '{8'h0D, 2, 32'h01230000}};

  msr_host_model msr_host_model_i (.clk_i(clk_i), .data_i(data_o), .cs_n_o(cs_n),
    .ps_n_o(ps_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(hdata));
  msr_readback msr_readback_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n),
    .ps_n_i(ps_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(hdata), .data_o(data_o),
    .data_oe_o(data_oe_o), .evt_i(evt_i), .vals_i(vals_i), .status_i(status_i),
    .core_busy_i(core_busy_i), .host_irq_i(host_irq_i), .cmd_err_o(cmd_err_o),
    .busy_o(busy_o), .signals_o(signals_o));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (cmd_err_o === 1'b1) errs++;

  task automatic final_report;
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // Pulses events for one cycle, then checks the word once both flops settled.
  task automatic pulse(input logic [13:0] e, input logic [15:0] exp);
    evt_i = e;
    @(negedge clk_i);
    evt_i = '0;
    repeat (2) @(negedge clk_i);
    `CHK("signals", exp, signals_o)
  endtask : pulse

  initial
  begin
    #200000;
    num_errors++;
    final_report();
  end

  initial
  begin
    {arst_n_i, core_busy_i, host_irq_i} = 3'b001;
    status_i = 8'hA4;
    evt_i = '0;
    vals_i = VALS;
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'b1;
    @(negedge clk_i);
    foreach (rows[i])
    begin
      msr_host_model_i.write_cmd(rows[i].cmd);
      msr_host_model_i.wait_ready();
      for (int k = 0; k < rows[i].len; k++)
      begin
        msr_host_model_i.read_byte(1'b1, b);
        vals_i = ~VALS;
        `CHK("byte", rows[i].val[31-8*k -: 8], b)
      end
      vals_i = VALS;
    end
    `CHK("reset", 16'h81A4, signals_o)
    pulse(14'h1C00, 16'h81A4);
    pulse(14'h0200, 16'h99A4);
    pulse(14'h01CC, 16'hDEA5);
    msr_host_model_i.write_cmd(8'h0C);
    msr_host_model_i.wait_ready();
    for (int k = 0; k < 2; k++)
    begin
      msr_host_model_i.read_byte(1'b1, b);
      `CHK("sig_byte", (k == 0) ? 8'hDE : 8'hA5, b)
    end
    pulse(14'h0232, 16'h99A4);
    pulse(14'h1000, 16'h99A4);
    pulse(14'h0200, 16'h81A4);
    pulse(14'h2000, 16'hA1A4);
    pulse(14'h0001, 16'h81A4);
    core_busy_i = 1'b1;
    msr_host_model_i.write_cmd(8'h0B);
    `CHK("busy_o", 1'b1, busy_o)
    msr_host_model_i.read_byte(1'b0, b);
    `CHK("busy_bit", 1'b1, b[0])
    msr_host_model_i.read_byte(1'b1, b);
    repeat (3) @(negedge clk_i);
    `CHK("err_busy", 0, errs)
    core_busy_i = 1'b0;
    msr_host_model_i.read_byte(1'b1, b);
    `CHK("err_idle", 1, errs)
    msr_host_model_i.write_cmd(8'h0A);
    msr_host_model_i.wait_ready();
    core_busy_i = 1'b1;
    msr_host_model_i.read_byte(1'b1, b);
    `CHK("busy_stale", 8'h3F, b)
    core_busy_i = 1'b0;
    msr_host_model_i.read_byte(1'b1, b);
    `CHK("no_advance", 8'h3F, b)
    msr_host_model_i.write_cmd(8'h3F);
    msr_host_model_i.read_byte(1'b1, b);
    `CHK("err_abort", 2, errs)
    pulse(14'h2008, 16'hA0A4);
    arst_n_i = 1'b0;
    @(negedge clk_i);
    `CHK("rst_sig", 16'h0100, signals_o)
    `CHK("rst_oe", 1'b0, data_oe_o)
    `CHK("rst_busy", 1'b0, busy_o)
    arst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK("rst_live", 16'h81A4, signals_o)
    final_report();
  end
endmodule : msr_readback_tb
